// ### logic/csw_clock_switch.v
// Design decisions made here: the register offsets and register access over Avalon-MM.
`timescale 1ns/10ps
`default_nettype none
`include "csw_defines.vh"

// Overview of operation
// - Auxiliary PLL powered only while its enable bit is set.
// - Read-only aux lock bit shows the auxiliary PLL lock state.
// - Aux divider fed by aux oscillator path or primary PLL VCO.
// - Three-bit aux divider code: 111 gives 1 down to 000 gives 256.
// - Aux PLL reference: fast RC if selected, else primary or nothing.
// - In Sleep the reference output runs only if run-in-sleep set.
// - Reference source is crystal when select is 1, else system clock.
// - Reference divided by two to the four-bit divider value.
// - Switching and fail-safe monitor only active when fuse is 0.
// - With switching off, switch request ignored and held at 0.
// - Request for the current source is cleared and aborted.
// - Valid switch start clears PLL lock and clock-fail bits.
// - Start new oscillator; wait start-up timer, PLL lock, or both for primary with PLL.
// - Wait 10 cycles of the new clock before changeover.
// - After changeover clear request and copy next into current.
// - Turn off old source; keep LOW_POWER_INTERNAL_RC and LP as required.
// - On oscillator failure raise trap and fall back to fast RC.
// - Fallback keeps the PLL if the failed source used it.
// - Auxiliary PLL multiplies its reference by sixteen.
module csw_clock_switch (
  // Clock and reset
  input  wire        mclk,
  input  wire        sys_rst,
  // Avalon-MM slave
  input  wire [4:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  output reg  [31:0] avs_readdata,
  output wire        avs_waitrequest,
  // Fuses and power state
  input  wire        switching_enable_fuse,
  input  wire [2:0]  initial_source_fuse,
  input  wire        sleep_mode,
  // Oscillator status
  input  wire        osc_startup_done,
  input  wire        pll_lock_in,
  input  wire        aux_pll_lock_in,
  input  wire [7:0]  src_tick,
  input  wire        osc_fail,
  // Clock ticks feeding the dividers
  input  wire        aux_osc_tick,
  input  wire        vco_tick,
  input  wire        xtal_tick,
  // Auxiliary clock outputs
  output wire        aux_pll_power,
  output wire [1:0]  aux_pll_ref,
  output wire [4:0]  aux_pll_mult,
  output reg         aux_clk_en,
  // Reference clock pin
  output reg         reference_clock_pin,
  output wire        reference_clock_pin_oe,
  // System clock control
  output wire [2:0]  sys_src_sel,
  output wire        frc_on,
  output wire        pri_on,
  output wire        sec_on,
  output wire        low_power_internal_rc_on,
  output wire        pll_on,
  output reg         fail_trap
);

  localparam S_IDLE  = 4'h1;
  localparam S_READY = 4'h2;
  localparam S_COUNT = 4'h4;
  localparam S_SWAP  = 4'h8;

  reg  [15:0] aux_ctl;
  reg  [15:0] ref_ctl;
  reg  [2:0]  cur_src;
  reg  [2:0]  nxt_src;
  reg         lock_bit;
  reg         cf_bit;
  reg         lp_keep;
  reg         req_bit;
  reg         wdt_en;
  reg  [1:0]  unlock;
  reg         sw_en;
  reg  [3:0]  state;
  reg  [3:0]  wait_cnt;
  reg  [7:0]  aux_cnt;
  reg  [14:0] ref_cnt;
  reg         ack;
  reg         rst_seen;

  wire        acc;
  wire        wr;
  wire        rd;
  wire [15:0] wd;
  wire        wr_osc;
  wire        aux_tick;
  wire        ref_src_tick;
  wire        ref_run;
  wire [7:0]  aux_last;
  wire [14:0] ref_last;
  wire        cur_pll;
  wire        nxt_pll;
  wire        busy;
  wire        fail_safe_monitor_en;
  wire        fail_go;
  wire        nxt_xtal;
  wire        nxt_ready;
  wire [15:0] osc_view;

  function pll_src;
    input [2:0] s;
    begin
      pll_src = (s == `CSW_SRC_INTERNAL_RC_WITH_PLL) || (s == `CSW_SRC_PRIPLL);
    end
  endfunction

  function frc_src;
    input [2:0] s;
    begin
      frc_src = (s == `CSW_SRC_FRC) || (s == `CSW_SRC_INTERNAL_RC_WITH_PLL) ||
                (s == `CSW_SRC_FRC16) || (s == `CSW_SRC_FRCN);
    end
  endfunction

  function pri_src;
    input [2:0] s;
    begin
      pri_src = (s == `CSW_SRC_PRI) || (s == `CSW_SRC_PRIPLL);
    end
  endfunction

  // One wait state: every access is answered at the second edge
  assign acc = (avs_read | avs_write) & ~ack;
  assign avs_waitrequest = acc;
  assign wr = avs_write & ack;
  assign rd = avs_read & ack;
  assign wd = avs_writedata[15:0];
  assign wr_osc = wr && (avs_address == `CSW_OFF_OSC);

  always @(posedge mclk) begin
    if (sys_rst) begin
      ack <= 1'b0;
    end else begin
      ack <= acc;
    end
  end

  // Software registers; the aux lock bit is never stored
  always @(posedge mclk) begin
    if (sys_rst) begin
      aux_ctl <= `CSW_AUX_RESET;
      ref_ctl <= `CSW_REF_RESET;
      wdt_en <= 1'b0;
      unlock <= 2'h0;
    end else if (wr) begin
      case (avs_address)
        `CSW_OFF_AUX: begin
          aux_ctl <= wd & `CSW_AUX_WMASK;
        end
        `CSW_OFF_REF: begin
          ref_ctl <= wd & `CSW_REF_WMASK;
        end
        `CSW_OFF_CFG: begin
          wdt_en <= wd[`CSW_CFG_WDT];
        end
        `CSW_OFF_OSC: begin
          unlock <= 2'h0;
        end
        `CSW_OFF_UNLOCK: begin
          // Any other word breaks the key sequence
          if (wd == `CSW_KEY1) begin
            unlock <= 2'h1;
          end else if (wd == `CSW_KEY2 && unlock == 2'h1) begin
            unlock <= 2'h2;
          end else begin
            unlock <= 2'h0;
          end
        end
        default: begin
        end
      endcase
    end
  end

  assign osc_view = {1'b0, cur_src, 1'b0, nxt_src, 2'b00, lock_bit, 1'b0, cf_bit, 1'b0, lp_keep, req_bit};

  // Read data is loaded in the wait cycle so it stands at the answering edge
  always @(posedge mclk) begin
    if (sys_rst) begin
      avs_readdata <= 32'h00000000;
    end else if (acc && avs_read) begin
      case (avs_address)
        `CSW_OFF_AUX: begin
          avs_readdata <= {16'h0000, (aux_ctl & `CSW_AUX_WMASK) | {1'b0, aux_pll_lock_in, 14'h0000}};
        end
        `CSW_OFF_REF: begin
          avs_readdata <= {16'h0000, ref_ctl};
        end
        `CSW_OFF_OSC: begin
          avs_readdata <= {16'h0000, osc_view};
        end
        `CSW_OFF_CFG: begin
          avs_readdata <= {31'h00000000, wdt_en};
        end
        default: begin
          avs_readdata <= 32'h00000000;
        end
      endcase
    end
  end

  // Auxiliary clock path
  assign aux_pll_power = aux_ctl[`CSW_AUX_EN];
  assign aux_pll_ref = aux_ctl[`CSW_AUX_AUX_PLL_INTERNAL_RC_SELECT] ? 2'h2 :
                       (aux_ctl[`CSW_AUX_REFSEL] ? 2'h1 : 2'h0);
  assign aux_pll_mult = `CSW_AUXILIARY_MULTIPLIER_LOOP_MULT;
  assign aux_tick = aux_ctl[`CSW_AUX_SRC] ? aux_osc_tick : vco_tick;

  // Terminal count for each divide code
  assign aux_last =
    (aux_ctl[`CSW_AUX_DIV_HI:`CSW_AUX_DIV_LO] == 3'h7) ? 8'h00 :
    (aux_ctl[`CSW_AUX_DIV_HI:`CSW_AUX_DIV_LO] == 3'h6) ? 8'h01 :
    (aux_ctl[`CSW_AUX_DIV_HI:`CSW_AUX_DIV_LO] == 3'h5) ? 8'h03 :
    (aux_ctl[`CSW_AUX_DIV_HI:`CSW_AUX_DIV_LO] == 3'h4) ? 8'h07 :
    (aux_ctl[`CSW_AUX_DIV_HI:`CSW_AUX_DIV_LO] == 3'h3) ? 8'h0f :
    (aux_ctl[`CSW_AUX_DIV_HI:`CSW_AUX_DIV_LO] == 3'h2) ? 8'h1f :
    (aux_ctl[`CSW_AUX_DIV_HI:`CSW_AUX_DIV_LO] == 3'h1) ? 8'h3f : 8'hff;

  always @(posedge mclk) begin
    if (sys_rst) begin
      aux_cnt <= 8'h00;
      aux_clk_en <= 1'b0;
    end else begin
      aux_clk_en <= 1'b0;
      if (aux_tick) begin
        if (aux_cnt >= aux_last) begin
          aux_cnt <= 8'h00;
          aux_clk_en <= 1'b1;
        end else begin
          aux_cnt <= aux_cnt + 8'h01;
        end
      end
    end
  end

  // Reference clock path; mclk itself stands for the system clock
  assign ref_src_tick = ref_ctl[`CSW_REF_SRC] ? xtal_tick : 1'b1;
  assign ref_run = ref_ctl[`CSW_REF_EN] & (~sleep_mode | ref_ctl[`CSW_REF_SLP]);
  assign ref_last = (15'h0001 << ref_ctl[`CSW_REF_DIV_HI:`CSW_REF_DIV_LO]) - 15'h0001;
  assign reference_clock_pin_oe = ref_ctl[`CSW_REF_EN];

  // Pin carries a one-cycle pulse per divided reference period
  always @(posedge mclk) begin
    if (sys_rst) begin
      ref_cnt <= 15'h0000;
      reference_clock_pin <= 1'b0;
    end else begin
      reference_clock_pin <= 1'b0;
      if (!ref_run) begin
        ref_cnt <= 15'h0000;
      end else if (ref_src_tick) begin
        if (ref_cnt >= ref_last) begin
          ref_cnt <= 15'h0000;
          reference_clock_pin <= 1'b1;
        end else begin
          ref_cnt <= ref_cnt + 15'h0001;
        end
      end
    end
  end

  // Clock switch sequencing
  assign cur_pll = pll_src(cur_src);
  assign nxt_pll = pll_src(nxt_src);
  assign busy = (state != S_IDLE);
  assign fail_safe_monitor_en = sw_en;
  assign fail_go = fail_safe_monitor_en & osc_fail & ~frc_src(cur_src);
  assign nxt_xtal = pri_src(nxt_src) || (nxt_src == `CSW_SRC_SEC);
  assign nxt_ready = (!nxt_xtal || osc_startup_done) && (!nxt_pll || pll_lock_in);
  assign sys_src_sel = cur_src;

  // Old source drops out once cur_src moves on, unless held by lp_keep, wdt_en or the monitor
  assign frc_on = frc_src(cur_src) | (busy & frc_src(nxt_src));
  assign pri_on = pri_src(cur_src) | (busy & pri_src(nxt_src));
  assign sec_on = (cur_src == `CSW_SRC_SEC) | (busy & (nxt_src == `CSW_SRC_SEC)) | lp_keep;
  assign low_power_internal_rc_on = (cur_src == `CSW_SRC_LOW_POWER_INTERNAL_RC) | (busy & (nxt_src == `CSW_SRC_LOW_POWER_INTERNAL_RC)) |
                   wdt_en | fail_safe_monitor_en;
  assign pll_on = cur_pll | (busy & nxt_pll);

  always @(posedge mclk) begin
    if (sys_rst) begin
      sw_en <= 1'b0;
      cur_src <= `CSW_SRC_FRC;
      nxt_src <= `CSW_SRC_FRC;
      state <= S_IDLE;
      wait_cnt <= 4'h0;
      req_bit <= 1'b0;
      lock_bit <= 1'b0;
      cf_bit <= 1'b0;
      lp_keep <= 1'b0;
      fail_trap <= 1'b0;
    end else begin
      fail_trap <= 1'b0;
      sw_en <= ~switching_enable_fuse;
      if (!pll_on) begin
        lock_bit <= 1'b0;
      end else if (pll_lock_in) begin
        lock_bit <= 1'b1;
      end
      if (wr_osc && !wd[`CSW_OSC_CF]) begin
        cf_bit <= 1'b0;
      end
      if (wr_osc && unlock == 2'h2 && sw_en) begin
        nxt_src <= wd[`CSW_OSC_NXT_HI:`CSW_OSC_NXT_LO];
        lp_keep <= wd[`CSW_OSC_LPKEEP];
        if (wd[`CSW_OSC_REQ] && !busy) begin
          req_bit <= 1'b1;
        end
      end
      case (state)
        S_IDLE: begin
          if (req_bit) begin
            if (cur_src == nxt_src) begin
              req_bit <= 1'b0;
            end else begin
              lock_bit <= 1'b0;
              cf_bit <= 1'b0;
              state <= S_READY;
            end
          end
        end
        S_READY: begin
          wait_cnt <= 4'h0;
          if (nxt_ready) begin
            state <= S_COUNT;
          end
        end
        S_COUNT: begin
          if (src_tick[nxt_src]) begin
            wait_cnt <= wait_cnt + 4'h1;
            if (wait_cnt == `CSW_NEW_CLK_WAIT - 4'h1) begin
              state <= S_SWAP;
            end
          end
        end
        S_SWAP: begin
          cur_src <= nxt_src;
          req_bit <= 1'b0;
          state <= S_IDLE;
        end
        default: begin
          state <= S_IDLE;
        end
      endcase
      // Failure overrides any switch in progress
      if (fail_go) begin
        cur_src <= cur_pll ? `CSW_SRC_INTERNAL_RC_WITH_PLL : `CSW_SRC_FRC;
        cf_bit <= 1'b1;
        fail_trap <= 1'b1;
        req_bit <= 1'b0;
        state <= S_IDLE;
      end
      if (state == 4'h0) begin
        state <= S_IDLE;
      end
      // Start-up source comes from the fuse, once per reset
      if (!rst_seen) begin
        cur_src <= initial_source_fuse;
        nxt_src <= initial_source_fuse;
      end
    end
  end

  always @(posedge mclk) begin
    if (sys_rst) begin
      rst_seen <= 1'b0;
    end else begin
      rst_seen <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// ### logic/csw_defines.vh
`ifndef CSW_DEFINES_VH
`define CSW_DEFINES_VH

// Register byte offsets
`define CSW_OFF_AUX      5'h00
`define CSW_OFF_REF      5'h04
`define CSW_OFF_OSC      5'h08
`define CSW_OFF_CFG      5'h0c
`define CSW_OFF_UNLOCK   5'h10

// Reset values
`define CSW_AUX_RESET    16'h2700
`define CSW_REF_RESET    16'h0000

// Auxiliary clock control fields
`define CSW_AUX_EN       15
`define CSW_AUX_LOCK     14
`define CSW_AUX_SRC      13
`define CSW_AUX_DIV_HI   10
`define CSW_AUX_DIV_LO   8
`define CSW_AUX_REFSEL   7
`define CSW_AUX_AUX_PLL_INTERNAL_RC_SELECT   6
`define CSW_AUX_WMASK    16'ha7c0

// Reference clock control fields
`define CSW_REF_EN       15
`define CSW_REF_SLP      13
`define CSW_REF_SRC      12
`define CSW_REF_DIV_HI   11
`define CSW_REF_DIV_LO   8
`define CSW_REF_WMASK    16'hbf00

// Oscillator control fields
`define CSW_OSC_CUR_HI   14
`define CSW_OSC_CUR_LO   12
`define CSW_OSC_NXT_HI   10
`define CSW_OSC_NXT_LO   8
`define CSW_OSC_LOCK     5
`define CSW_OSC_CF       3
`define CSW_OSC_LPKEEP   1
`define CSW_OSC_REQ      0

// Configuration register fields
`define CSW_CFG_WDT      0

// Unlock keys, one per step
`define CSW_KEY1         16'h0046
`define CSW_KEY2         16'h0057

// Source codes
`define CSW_SRC_FRC      3'h0
`define CSW_SRC_INTERNAL_RC_WITH_PLL   3'h1
`define CSW_SRC_PRI      3'h2
`define CSW_SRC_PRIPLL   3'h3
`define CSW_SRC_SEC      3'h4
`define CSW_SRC_LOW_POWER_INTERNAL_RC     3'h5
`define CSW_SRC_FRC16    3'h6
`define CSW_SRC_FRCN     3'h7

// Timing
`define CSW_NEW_CLK_WAIT 4'ha
`define CSW_AUXILIARY_MULTIPLIER_LOOP_MULT    5'h10

`endif

// ### test/csw_clock_switch_sva.sv
`timescale 1ns/10ps
`default_nettype none
`include "csw_defines.vh"
module csw_clock_switch_sva (
  // Clock and reset
  input wire logic        mclk,
  input wire logic        sys_rst,
  // Register bus
  input wire logic [4:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  // Fuses and outputs
  input wire logic        switching_enable_fuse,
  input wire logic [2:0]  initial_source_fuse,
  input wire logic        aux_pll_power,
  input wire logic [4:0]  aux_pll_mult,
  input wire logic        reference_clock_pin_oe,
  input wire logic [2:0]  sys_src_sel,
  input wire logic        fail_trap
);
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  wire wr_aux = avs_write && !avs_waitrequest && avs_address == `CSW_OFF_AUX;
  wire wr_ref = avs_write && !avs_waitrequest && avs_address == `CSW_OFF_REF;
  wire rd_osc = avs_read && !avs_waitrequest && avs_address == `CSW_OFF_OSC;

  chk_auxiliary_multiplier_loop_factor: assert property (aux_pll_mult == `CSW_AUXILIARY_MULTIPLIER_LOOP_MULT)
    else $error("aux multiplier wrong");
  chk_aux_power_on: assert property (wr_aux && avs_writedata[15] |-> ##[1:3] aux_pll_power)
    else $error("aux pll not powered");
  chk_aux_power_off: assert property (wr_aux && !avs_writedata[15] |-> ##[1:3] !aux_pll_power)
    else $error("aux pll still powered");
  chk_ref_oe_off: assert property (wr_ref && !avs_writedata[15] |-> ##[1:3] !reference_clock_pin_oe)
    else $error("reference pin still driven");
  chk_fused_source: assert property (switching_enable_fuse && !$past(sys_rst) |-> sys_src_sel == initial_source_fuse)
    else $error("source differs from fuse");
  chk_fused_no_trap: assert property (switching_enable_fuse |-> !fail_trap)
    else $error("trap with monitor off");
  chk_trap_to_rc: assert property ($rose(fail_trap) |-> ##[0:20] sys_src_sel inside {`CSW_SRC_FRC, `CSW_SRC_INTERNAL_RC_WITH_PLL})
    else $error("no fallback to fast rc");
  chk_req_held: assert property (rd_osc && switching_enable_fuse |-> avs_readdata[0] == 1'b0)
    else $error("switch request not held low");
  chk_cur_fused: assert property (rd_osc && switching_enable_fuse |-> avs_readdata[14:12] == initial_source_fuse)
    else $error("current source not from fuse");
endmodule
bind csw_clock_switch csw_clock_switch_sva u_sva (.*);
`default_nettype wire

// ### test/csw_clock_switch_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "csw_defines.vh"
module csw_clock_switch_tb_top;
  logic        mclk, sys_rst, avs_read, avs_write, avs_waitrequest, sleep_mode, osc_fail, tk;
  logic        switching_enable_fuse, osc_startup_done, pll_lock_in, aux_pll_lock_in;
  logic        aux_pll_power, reference_clock_pin, reference_clock_pin_oe, frc_on, pri_on, low_power_internal_rc_on, fail_trap;
  logic [2:0]  initial_source_fuse, sys_src_sel;
  logic [4:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, q;
  wire         aux_osc_tick = tk;
  wire         vco_tick = tk;
  wire         xtal_tick = tk;
  wire  [7:0]  src_tick = {8{tk}};
  int          failures, compares, r;

  csw_clock_switch dut (.*, .aux_pll_ref(), .aux_pll_mult(), .aux_clk_en(), .sec_on(), .pll_on());

  initial begin
    mclk = 0;
    forever #50 mclk = ~mclk;
  end
  // Every source ticks once per two cycles
  always @(posedge mclk) tk <= ~tk;

  task chk(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      failures++;
      $display("ERROR at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task final_report;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task fail_out;
    failures++;
    final_report;
  endtask
  task bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    // Inputs hold still until the accepting edge
    do begin
      @(posedge mclk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 64);
    q = avs_readdata;
    if (n >= 64) fail_out;
    avs_write <= 0;
    avs_read <= 0;
  endtask
  task settle;
    repeat (4) @(posedge mclk);
    @(negedge mclk);
  endtask
  task osc_set(input logic [2:0] s, input logic rq);
    bus(1, `CSW_OFF_UNLOCK, {16'h0000, `CSW_KEY1});
    bus(1, `CSW_OFF_UNLOCK, {16'h0000, `CSW_KEY2});
    bus(1, `CSW_OFF_OSC, {21'h0, s, 7'h0, rq});
  endtask
  task poll_req;
    int n;
    n = 0;
    do begin
      bus(0, `CSW_OFF_OSC, 0);
      n++;
    end while (q[0] !== 1'b0 && n < 100);
    if (n >= 100) fail_out;
  endtask
  task rst(input logic f, input logic [2:0] s);
    @(posedge mclk);
    sys_rst <= 1;
    switching_enable_fuse <= f;
    initial_source_fuse <= s;
    repeat (6) @(posedge mclk);
    sys_rst <= 0;
  endtask
  task rises(input int c);
    logic p;
    r = 0;
    p = reference_clock_pin;
    repeat (c) begin
      @(negedge mclk);
      if (reference_clock_pin === 1'b1 && p !== 1'b1) r++;
      p = reference_clock_pin;
    end
  endtask

  task t_regs;
    bus(0, `CSW_OFF_AUX, 0);
    chk(q, {16'h0, `CSW_AUX_RESET});
    bus(0, `CSW_OFF_REF, 0);
    chk(q, 0);
    bus(1, 5'h14, 32'hffffffff);
    settle;
    chk(aux_pll_power, 0);
    bus(1, `CSW_OFF_AUX, 32'hffff);
    bus(0, `CSW_OFF_AUX, 0);
    chk(q, {16'h0, `CSW_AUX_WMASK});
    chk(aux_pll_power, 1);
    aux_pll_lock_in <= 1;
    settle;
    bus(0, `CSW_OFF_AUX, 0);
    chk(q[14], 1);
    aux_pll_lock_in <= 0;
    bus(1, `CSW_OFF_AUX, 0);
    settle;
    chk(aux_pll_power, 0);
  endtask
  task t_ref;
    for (int d = 0; d < 4; d += 2) begin
      bus(1, `CSW_OFF_REF, {16'h0, 4'h1, d[3:0], 8'h0});
      bus(1, `CSW_OFF_REF, {16'h0, 4'h9, d[3:0], 8'h0});
      rises(128);
      chk(r inside {[(64 >> d) - 1:(64 >> d) + 1]}, 1);
    end
    chk(reference_clock_pin_oe, 1);
    @(posedge mclk);
    sleep_mode <= 1;
    rises(64);
    chk(r, 0);
    @(posedge mclk);
    sleep_mode <= 0;
    bus(1, `CSW_OFF_REF, 32'hb200);
    @(posedge mclk);
    sleep_mode <= 1;
    rises(64);
    chk(r inside {[7:9]}, 1);
    @(posedge mclk);
    sleep_mode <= 0;
    bus(1, `CSW_OFF_REF, 0);
    settle;
    chk(reference_clock_pin_oe, 0);
  endtask
  task t_fused;
    rst(1, `CSW_SRC_PRI);
    bus(0, `CSW_OFF_OSC, 0);
    chk(q[14:12], `CSW_SRC_PRI);
    osc_set(`CSW_SRC_FRC, 0);
    osc_set(`CSW_SRC_FRC, 1);
    bus(0, `CSW_OFF_OSC, 0);
    chk(q[0], 0);
    osc_fail <= 1;
    @(posedge mclk);
    osc_fail <= 0;
    settle;
    chk(sys_src_sel, `CSW_SRC_PRI);
    chk(fail_trap, 0);
  endtask
  task t_switch;
    int n;
    rst(0, `CSW_SRC_FRC);
    osc_set(`CSW_SRC_FRC, 0);
    osc_set(`CSW_SRC_FRC, 1);
    poll_req;
    chk(sys_src_sel, `CSW_SRC_FRC);
    osc_set(`CSW_SRC_PRI, 0);
    osc_set(`CSW_SRC_PRI, 1);
    repeat (40) @(posedge mclk);
    bus(0, `CSW_OFF_OSC, 0);
    chk(q[0], 1);
    osc_startup_done <= 1;
    poll_req;
    chk(q[14:12], `CSW_SRC_PRI);
    chk(q[3], 0);
    settle;
    chk(sys_src_sel, `CSW_SRC_PRI);
    chk({frc_on, pri_on, low_power_internal_rc_on}, 3'b011);
    @(posedge mclk);
    osc_fail <= 1;
    @(posedge mclk);
    osc_fail <= 0;
    n = 0;
    while (fail_trap !== 1'b1 && n < 50) begin
      @(negedge mclk);
      n++;
    end
    chk(n < 50, 1);
    settle;
    chk(sys_src_sel, `CSW_SRC_FRC);
  endtask

  initial begin
    {sys_rst, tk, avs_read, avs_write, sleep_mode, osc_fail, aux_pll_lock_in, pll_lock_in} = 8'h80;
    {switching_enable_fuse, osc_startup_done, initial_source_fuse} = 5'h10;
    avs_address = 0;
    avs_writedata = 0;
    failures = 0;
    compares = 0;
    rst(1, `CSW_SRC_FRC);
    t_regs;
    t_ref;
    t_fused;
    t_switch;
    final_report;
  end
endmodule
`default_nettype wire
